// ==== verilog/lvi_pkg.sv ====
// constants shared by the supply monitor: register map, field layout, reset values, filter counts
// assumes an 8-bit register port with a 16-bit byte address
package lvi_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [15:0] STATUS_ADDR = 16'hFE0F;
  localparam logic [15:0] CONFIG_ADDR = 16'hFE10;
  localparam logic [15:0] EVT_STATUS_ADDR = 16'hFE11;
  localparam logic [15:0] EVT_CLEAR_ADDR = 16'hFE12;
  localparam logic [15:0] EVT_ENABLE_ADDR = 16'hFE13;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FLAG_BIT = 0;
  localparam int CFG_PWR_BIT = 0;
  localparam int CFG_RST_BIT = 1;
  localparam int CFG_STOP_BIT = 2;
  localparam int EVT_FLAG_BIT = 0;
  localparam int EVT_TRIP_BIT = 1;
  localparam int EVT_W = 2;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [2:0] CONFIG_RESET = 3'h3;
  localparam logic [1:0] EVT_ENABLE_RESET = 2'h0;
  // ************************************************************
  // filter counts
  // ************************************************************
  localparam int CPU_TRIP_CYCLES = 9;
  localparam int XTAL_MIN_TICKS = 32;
  localparam int XTAL_MAX_TICKS = 40;
  localparam int XTAL_SET_TICKS = XTAL_MIN_TICKS;
  // ************************************************************
  // monitor states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WATCH = 3'b010,
    ST_HOLD = 3'b100
  } mon_state_t;
endpackage : lvi_pkg

// ==== verilog/supply_cmp_if.sv ====
// comparator view shared between the monitor and its run-length filters
// assumes both ends sit on core_clk
`timescale 1ns/10ps
interface supply_cmp_if;
  logic below_falling;
  logic active;
  modport src (output below_falling, output active);
  modport filt (input below_falling, input active);
endinterface : supply_cmp_if

// ==== verilog/run_filter.sv ====
// counts consecutive qualified steps with the supply below the falling trip level
// assumes the comparator group is synchronous to core_clk
`timescale 1ns/10ps
module run_filter
  import lvi_pkg::*;
#(
  parameter int THRESHOLD = CPU_TRIP_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // comparator group and count enable
  supply_cmp_if.filt cmp,
  input wire logic step,
  // result
  output logic reached
);
  localparam int CW = $clog2(THRESHOLD + 1);
  localparam logic [CW-1:0] LIMIT = CW'(THRESHOLD);
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    // any step out of the low band restarts the run
    if (!(cmp.active && cmp.below_falling))
      count_nxt = '0;
    else if (step && count_r != LIMIT)
      count_nxt = count_r + CW'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign reached = (count_r == LIMIT);
endmodule : run_filter

// ==== verilog/edge_tick.sv ====
// one-cycle pulse on each rising edge of a slow clock sampled as a plain input
// assumes the slow clock is well under half of core_clk
`timescale 1ns/10ps
module edge_tick
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // sampled level and pulse
  input wire logic level_in,
  output logic tick
);
  logic prev_r;
  logic prev_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    prev_nxt = level_in;
    tick_nxt = level_in && !prev_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      // follow the pin through reset, so a slow clock high at release gives no false tick
      prev_r <= prev_nxt;
      tick_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : edge_tick

// ==== verilog/low_voltage_inhibit_monitor.sv ====
// supply monitor control: filters the comparator, requests reset, keeps the status flag
// assumes the analog comparator outputs and mode levels are synchronous to core_clk
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] monitor enabled straight out of reset
// [RULE_02] comparator ignored while power enable clear
// [RULE_03] reset after nine consecutive low cycles
// [RULE_04] stop enable keeps monitor alive in stop
// [RULE_05] one cycle above rising level releases reset
// [RULE_06] status flag follows qualified comparator output
// [RULE_07] reset pin driven low during hold
// [RULE_08] flag readable at FE0F, other bits zero
// [RULE_09] polled use: power on, reset off
// [RULE_10] forced-reset use: both bits set
// [RULE_11] flag sets after 32 to 40 crystal ticks
// [RULE_12] above rising clears, between levels holds
// [RULE_13] system reset clears the flag
// [RULE_14] monitor core raises no CPU interrupt
// [RULE_15] wait mode keeps monitor and reset active
// [RULE_16] stop with both bits set still resets; the code also needs stop enable set before it resets in stop
// [RULE_17] stop without stop enable: monitor inactive
module low_voltage_inhibit_monitor
  import lvi_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // analog comparator and slow clock
  input wire logic below_falling,
  input wire logic above_rising,
  input wire logic crystal_clock,
  // power modes
  input wire logic wait_mode,
  input wire logic stop_mode,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // reset request and reset pin
  output logic lvi_reset_req,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // event summary line
  output logic event_irq
);
  // ************************************************************
  // register decode
  // ************************************************************
  logic cfg_we;
  logic evt_clr_we;
  logic evt_en_we;

  // the status and event status addresses decode no write: both are read-only
  assign cfg_we = reg_wr && (reg_addr == CONFIG_ADDR);
  assign evt_clr_we = reg_wr && (reg_addr == EVT_CLEAR_ADDR);
  assign evt_en_we = reg_wr && (reg_addr == EVT_ENABLE_ADDR);

  // ************************************************************
  // configuration register
  // ************************************************************
  logic [2:0] config_r;
  logic [2:0] config_nxt;
  logic power_en;
  logic reset_en;
  logic stop_en;
  logic active;

  assign power_en = config_r[CFG_PWR_BIT];
  assign reset_en = config_r[CFG_RST_BIT];
  assign stop_en = config_r[CFG_STOP_BIT];
  // wait mode does not gate the monitor; stop does unless enabled
  assign active = power_en && (!stop_mode || stop_en); // [RULE_02] [RULE_04] [RULE_15] [RULE_17]

  always_comb
  begin
    config_nxt = config_r;
    if (cfg_we)
      config_nxt = reg_wdata[2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      config_r <= CONFIG_RESET; // [RULE_01]
    else
      config_r <= config_nxt;
  end

  // ************************************************************
  // comparator filters
  // ************************************************************
  supply_cmp_if cmp_bus ();
  logic cpu_trip;
  logic xtal_tick;
  logic xtal_trip;

  assign cmp_bus.below_falling = below_falling;
  assign cmp_bus.active = active;

  run_filter #(
    .THRESHOLD(CPU_TRIP_CYCLES)
  ) cpu_filter (
    .core_clk(core_clk),
    .reset(reset),
    .cmp(cmp_bus),
    .step(1'b1),
    .reached(cpu_trip)
  ); // [RULE_03]

  edge_tick xtal_edge (
    .core_clk(core_clk),
    .reset(reset),
    .level_in(crystal_clock),
    .tick(xtal_tick)
  );

  // set at the low end of the allowed window; the tick is one cycle late, well inside it
  run_filter #(
    .THRESHOLD(XTAL_SET_TICKS)
  ) xtal_filter (
    .core_clk(core_clk),
    .reset(reset),
    .cmp(cmp_bus),
    .step(xtal_tick),
    .reached(xtal_trip)
  ); // [RULE_11]

  // ************************************************************
  // reset hold state machine
  // ************************************************************
  mon_state_t state_r;
  mon_state_t state_nxt;
  logic trip_event;

  always_comb
  begin
    state_nxt = state_r;
    trip_event = 1'b0;
    unique case (state_r)
      ST_OFF:
      begin
        if (active)
          state_nxt = ST_WATCH;
      end
      ST_WATCH:
      begin
        if (!active)
          state_nxt = ST_OFF;
        else if (reset_en && cpu_trip) // [RULE_03] [RULE_10] [RULE_16]
        begin
          state_nxt = ST_HOLD;
          trip_event = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // hold regardless of config until supply recovers
        if (above_rising) // [RULE_05]
          state_nxt = active ? ST_WATCH : ST_OFF;
      end
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // the reset request and pin ride the same state, so they cannot drift apart
  assign lvi_reset_req = (state_r == ST_HOLD); // [RULE_15] [RULE_16]
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = (state_r == ST_HOLD); // [RULE_07]

  // ************************************************************
  // status flag
  // ************************************************************
  logic flag_r;
  logic flag_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    if (above_rising)
      flag_nxt = 1'b0; // [RULE_12]
    else if (xtal_trip)
      flag_nxt = 1'b1; // [RULE_06] [RULE_11]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      flag_r <= 1'b0; // [RULE_13]
    else
      flag_r <= flag_nxt;
  end

  // ************************************************************
  // event bits, kept apart from the monitor core
  // ************************************************************
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_enable;
  logic [EVT_W-1:0] evt_set;

  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_FLAG_BIT] = flag_nxt && !flag_r;
    evt_set[EVT_TRIP_BIT] = trip_event;
  end

  // one sticky bit and one enable per event source
  for (genvar i = 0; i < EVT_W; i++)
  begin : g_evt
    logic status_r;
    logic status_nxt;
    logic enable_r;
    logic enable_nxt;

    always_comb
    begin
      status_nxt = status_r;
      enable_nxt = enable_r;
      if (evt_clr_we && reg_wdata[i])
        status_nxt = 1'b0;
      // a new event in the clearing cycle survives the clear
      if (evt_set[i])
        status_nxt = 1'b1;
      if (evt_en_we)
        enable_nxt = reg_wdata[i];
    end

    always_ff @(posedge core_clk)
    begin
      if (reset)
      begin
        status_r <= 1'b0;
        enable_r <= EVT_ENABLE_RESET[i];
      end
      else
      begin
        status_r <= status_nxt;
        enable_r <= enable_nxt;
      end
    end

    assign evt_status[i] = status_r;
    assign evt_enable[i] = enable_r;
  end

  // disabled out of reset, so the monitor alone never interrupts the CPU
  assign event_irq = |(evt_status & evt_enable); // [RULE_14]

  // ************************************************************
  // register words
  // ************************************************************
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] config_word;
  logic [DATA_W-1:0] evt_status_word;
  logic [DATA_W-1:0] evt_enable_word;

  // unimplemented bits read as zero
  always_comb
  begin
    status_word = '0;
    status_word[FLAG_BIT] = flag_r; // [RULE_08]
    config_word = '0;
    config_word[2:0] = config_r;
    evt_status_word = '0;
    evt_status_word[EVT_W-1:0] = evt_status;
    evt_enable_word = '0;
    evt_enable_word[EVT_W-1:0] = evt_enable;
  end

  // ************************************************************
  // read port
  // ************************************************************
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        STATUS_ADDR: rdata_nxt = status_word; // [RULE_08]
        CONFIG_ADDR: rdata_nxt = config_word;
        EVT_STATUS_ADDR: rdata_nxt = evt_status_word;
        EVT_ENABLE_ADDR: rdata_nxt = evt_enable_word;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;
endmodule : low_voltage_inhibit_monitor

// ==== sim/lvi_monitor.sv ====
// port-level checker for the supply monitor
// assumes it is bound to low_voltage_inhibit_monitor
`timescale 1ns/10ps
module lvi_monitor_chk
  import lvi_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // stimulus side
  input wire logic below_falling,
  input wire logic above_rising,
  input wire logic stop_mode,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // design outputs
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic lvi_reset_req,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe
);
  logic [3:0] run_r;
  logic [3:0] run_nxt;
  logic [2:0] cfg_r;
  logic [2:0] cfg_nxt;
  logic rd_st;
  assign rd_st = reg_rd && reg_addr == STATUS_ADDR;
  // shadow of config and of the raw low run, so trips can be judged from the ports
  always_comb
  begin
    run_nxt = !below_falling ? 4'h0 : (run_r == 4'hF) ? run_r : run_r + 4'h1;
    cfg_nxt = (reg_wr && reg_addr == CONFIG_ADDR) ? reg_wdata[2:0] : cfg_r;
  end
  always_ff @(posedge core_clk)
  begin
    run_r <= reset ? 4'h0 : run_nxt;
    cfg_r <= reset ? CONFIG_RESET : cfg_nxt;
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_pin_oe; rst_pin_oe == lvi_reset_req; endproperty
  property p_pin_lo; rst_pin_oe |-> !rst_pin_o; endproperty
  property p_qual; $rose(lvi_reset_req) |-> $past(run_r) >= 4'h9; endproperty
  property p_pwr; $rose(lvi_reset_req) |-> $past(cfg_r[CFG_PWR_BIT]); endproperty
  property p_rst; $rose(lvi_reset_req) |-> $past(cfg_r[CFG_RST_BIT]); endproperty
  property p_stop; $rose(lvi_reset_req) |-> !$past(stop_mode) || $past(cfg_r[2]); endproperty
  property p_hold; lvi_reset_req && !above_rising |=> lvi_reset_req; endproperty
  property p_rel; lvi_reset_req && above_rising |=> !lvi_reset_req; endproperty
  property p_rsvd; rd_st |=> reg_rdata[7:1] == 7'h00; endproperty
  property p_clr; rd_st && $past(above_rising) |=> !reg_rdata[0]; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable differs from request");
  a_pin_lo: assert property (p_pin_lo) else $error("reset pin not driven low");
  a_qual: assert property (p_qual) else $error("reset after short low run");
  a_pwr: assert property (p_pwr) else $error("reset with monitor off");
  a_rst: assert property (p_rst) else $error("reset in polled use");
  a_stop: assert property (p_stop) else $error("reset in stop without stop enable");
  a_hold: assert property (p_hold) else $error("reset dropped early");
  a_rel: assert property (p_rel) else $error("reset not released");
  a_rsvd: assert property (p_rsvd) else $error("unimplemented status bits set");
  a_clr: assert property (p_clr) else $error("flag not cleared");
  c_trip: cover property ($rose(lvi_reset_req));
  c_rel: cover property ($fell(lvi_reset_req));
  c_flag: cover property (rd_st ##1 reg_rdata[0]);
endmodule : lvi_monitor_chk
bind low_voltage_inhibit_monitor lvi_monitor_chk u_lvi_monitor_chk (.core_clk, .reset,
  .below_falling, .above_rising, .stop_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .lvi_reset_req, .rst_pin_o, .rst_pin_oe);

// ==== sim/low_voltage_inhibit_monitor_bench.sv ====
// self-checking bench for the supply monitor
// assumes design sources and checker are compiled first
`timescale 1ns/10ps
module low_voltage_inhibit_monitor_bench
  import lvi_pkg::*;
;
  logic core_clk = 1'h0, reset = 1'h1, below_falling = 1'h0, above_rising = 1'h0;
  logic wait_mode = 1'h0, stop_mode = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 16'h0000;
  logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata, rd_v;
  logic lvi_reset_req, rst_pin_o, rst_pin_oe, event_irq;
  logic [2:0] xdiv = 3'h0;
  logic [3:0] mode_tab [6] = '{4'h3, 4'h3, 4'h1, 4'h0, 4'hB, 4'hF};
  int fail_count = 0, cmp_count = 0, cfg_m, n;
  wire crystal_clock = xdiv[2];
  always #5 core_clk = ~core_clk;
  // crystal at an eighth of core_clk, free running
  always @(posedge core_clk) xdiv <= xdiv + 3'h1;
  low_voltage_inhibit_monitor u_low_voltage_inhibit_monitor (.core_clk, .reset,
    .below_falling, .above_rising, .crystal_clock, .wait_mode, .stop_mode, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lvi_reset_req, .rst_pin_o, .rst_pin_oe,
    .event_irq);
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // callers step 1 ns past the edge first, so the values passed in have settled
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    if (a == CONFIG_ADDR) cfg_m = d;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask : rd
  task automatic low(input int k);
    @(posedge core_clk);
    below_falling <= 1'h1;
    repeat (k) @(posedge core_clk);
    below_falling <= 1'h0;
  endtask : low
  task automatic rise();
    @(posedge core_clk);
    above_rising <= 1'h1;
    @(posedge core_clk);
    above_rising <= 1'h0;
  endtask : rise
  task automatic trip(input int k, input logic e);
    low(k);
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset_req", {7'h0, e}, {7'h0, lvi_reset_req});
    chk("pin_oe", {7'h0, e}, {7'h0, rst_pin_oe});
    chk("pin_o", 8'h00, {7'h0, rst_pin_o});
    repeat (5) @(posedge core_clk);
    #1;
    chk("held", {7'h0, e}, {7'h0, lvi_reset_req});
    rise();
    #1;
    chk("released", 8'h00, {7'h0, lvi_reset_req});
  endtask : trip
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    void'($urandom(62));
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    cfg_m = 3;
    rd(CONFIG_ADDR);
    chk("config", 8'h03, rd_v);
    wr(STATUS_ADDR, 8'hFF);
    rd(STATUS_ADDR);
    chk("status", 8'h00, rd_v);
    rd(16'hFE20);
    chk("unmapped", 8'h00, rd_v);
    for (int i = 0; i < 6; i++)
    begin
      wr(CONFIG_ADDR, {5'h0, mode_tab[i][2:0]});
      stop_mode <= mode_tab[i][3];
      wait_mode <= (i == 1);
      n = (i == 0) ? 8 : 9 + $urandom % 8;
      trip(n, n >= 9 && cfg_m[0] && cfg_m[1] && (!mode_tab[i][3] || cfg_m[2]));
    end
    stop_mode <= 1'h0;
    wr(EVT_CLEAR_ADDR, 8'h03);
    wr(CONFIG_ADDR, 8'h01);
    low(240);
    rd(STATUS_ADDR);
    chk("flag_short", 8'h00, rd_v);
    low(360);
    rd(STATUS_ADDR);
    chk("flag_long", 8'h01, rd_v);
    rd(EVT_STATUS_ADDR);
    chk("event", 8'h01, rd_v);
    chk("irq_masked", 8'h00, {7'h0, event_irq});
    wr(EVT_ENABLE_ADDR, 8'h01);
    #1 chk("irq_on", 8'h01, {7'h0, event_irq});
    wr(EVT_CLEAR_ADDR, 8'h01);
    #1 chk("irq_clr", 8'h00, {7'h0, event_irq});
    @(posedge core_clk);
    above_rising <= 1'h1;
    rd(STATUS_ADDR);
    chk("flag_clr", 8'h00, rd_v);
    @(posedge core_clk);
    above_rising <= 1'h0;
    low(360);
    rd(STATUS_ADDR);
    chk("flag_pre_rst", 8'h01, rd_v);
    @(posedge core_clk);
    reset <= 1'h1;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    rd(STATUS_ADDR);
    chk("flag_rst", 8'h00, rd_v);
    rd(CONFIG_ADDR);
    chk("config_rst", 8'h03, rd_v);
    tally_and_finish();
  end
endmodule : low_voltage_inhibit_monitor_bench
